// ==== famc_map.svh ====
`ifndef FAMC_MAP_SVH
`define FAMC_MAP_SVH

// Byte address width of the largest array (128 KB)
`define FAMC_ADDR_W 17
`define FAMC_KB_SMALL 64
`define FAMC_KB_LARGE 128

// Access size field encodings
`define FAMC_ASZ_HALF 2'h1
`define FAMC_ASZ_WORD 2'h2
`define FAMC_ASZ_RESET 2'h2

// CPU transfer sizes
`define FAMC_SZ_BYTE 2'h0
`define FAMC_SZ_HALF 2'h1
`define FAMC_SZ_WORD 2'h2

// Command write addresses (low 16 bits) and data (low 8 bits)
`define FAMC_CMD_ADDR_A 16'haa8
`define FAMC_CMD_ADDR_B 16'h554
`define FAMC_CMD_UNLOCK_A 8'haa
`define FAMC_CMD_UNLOCK_B 8'h55
`define FAMC_CMD_PROG 8'ha0
`define FAMC_CMD_ERASE 8'h80
`define FAMC_CMD_CHIP 8'h10
`define FAMC_CMD_SECTOR 8'h30
`define FAMC_CMD_RESET 8'hf0

// Cycles from a taken request to its answer
`define FAMC_RD_LAT 2

`endif

// ==== famc_pkg.sv ====
`include "famc_map.svh"

package famc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_UNL1,
        ST_UNL2,
        ST_PGM,
        ST_ERS1,
        ST_ERS2,
        ST_ERS3
    } famc_seq_st_t;

    typedef enum logic [1:0] {
        OP_PROG,
        OP_CHIP,
        OP_SECT
    } famc_op_t;

    typedef struct packed {
        famc_seq_st_t st;
        logic start;
        famc_op_t op;
        logic [`FAMC_ADDR_W-1:0] addr;
        logic [15:0] data;
    } famc_seq_state_t;

    typedef struct packed {
        logic [1:0] access_size_field;
        logic prog;
        logic s1_vld;
        logic s1_we;
        logic s1_err;
        logic [1:0] s1_size;
        logic [1:0] s1_lane;
        logic arr_rd;
        logic [`FAMC_ADDR_W-1:2] arr_addr;
        logic [31:0] rdata;
        logic ack;
        logic err;
        logic alg_start;
        famc_op_t alg_op;
        logic [`FAMC_ADDR_W-1:0] alg_addr;
        logic [15:0] alg_data;
    } famc_ctrl_state_t;

endpackage

// ==== famc_cmd_seq.sv ====
`timescale 1ns/1ps
`include "famc_map.svh"

module famc_cmd_seq
(
    // Clock and reset
    input logic ref_clk_in,
    input logic rstn_in,
    // Half-word command writes
    input logic clear_in,
    input logic wr_in,
    input logic [`FAMC_ADDR_W-1:0] wr_addr_in,
    input logic [15:0] wr_data_in,
    // Decoded operation
    output logic start_out,
    output famc_pkg::famc_op_t op_out,
    output logic [`FAMC_ADDR_W-1:0] addr_out,
    output logic [15:0] data_out
);

    famc_pkg::famc_seq_state_t q;
    famc_pkg::famc_seq_state_t d;

    // Only low address and data bits carry the command
    function automatic logic hit(input logic [15:0] a, input logic [7:0] v,
        input logic [15:0] ea, input logic [7:0] ev);
        hit = (a == ea) && (v == ev);
    endfunction

    always_comb
    begin
        d = q;
        d.start = 1'b0;
        if (clear_in)
        begin
            d.st = famc_pkg::ST_IDLE;
        end
        else if (wr_in)
        begin
            d.st = famc_pkg::ST_IDLE;
            // Reset code aborts any sequence except a program data cycle
            if (q.st == famc_pkg::ST_PGM || wr_data_in[7:0] != `FAMC_CMD_RESET)
            begin
                case (q.st)
                    famc_pkg::ST_IDLE:
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_A, `FAMC_CMD_UNLOCK_A))
                            d.st = famc_pkg::ST_UNL1;
                    famc_pkg::ST_UNL1:
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_B, `FAMC_CMD_UNLOCK_B))
                            d.st = famc_pkg::ST_UNL2;
                    famc_pkg::ST_UNL2:
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_A, `FAMC_CMD_PROG))
                            d.st = famc_pkg::ST_PGM;
                        else if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_A, `FAMC_CMD_ERASE))
                            d.st = famc_pkg::ST_ERS1;
                    famc_pkg::ST_PGM:
                    begin
                        d.start = 1'b1; // [RQ7]
                        d.op = famc_pkg::OP_PROG; // [RQ8]
                        d.addr = wr_addr_in;
                        d.data = wr_data_in;
                    end
                    famc_pkg::ST_ERS1:
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_A, `FAMC_CMD_UNLOCK_A))
                            d.st = famc_pkg::ST_ERS2;
                    famc_pkg::ST_ERS2:
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_B, `FAMC_CMD_UNLOCK_B))
                            d.st = famc_pkg::ST_ERS3;
                    famc_pkg::ST_ERS3:
                    begin
                        d.addr = wr_addr_in;
                        d.data = wr_data_in;
                        if (hit(wr_addr_in[15:0], wr_data_in[7:0],
                            `FAMC_CMD_ADDR_A, `FAMC_CMD_CHIP))
                        begin
                            d.start = 1'b1; // [RQ9]
                            d.op = famc_pkg::OP_CHIP;
                        end
                        else if (wr_data_in[7:0] == `FAMC_CMD_SECTOR)
                        begin
                            d.start = 1'b1; // [RQ9]
                            d.op = famc_pkg::OP_SECT;
                        end
                    end
                    default:
                        d.st = famc_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            q <= '0;
        else
            q <= d;
    end

    assign start_out = q.start;
    assign op_out = q.op;
    assign addr_out = q.addr;
    assign data_out = q.data;

endmodule

// ==== famc_access_ctrl.sv ====
// How it works
// [RQ1] Reset always returns to word-read mode
// [RQ2] Word-read mode serves 32-bit reads and fetch
// [RQ3] Word-read mode ignores writes, never starts algorithm
// [RQ4] Half-word encoding enters programming mode
// [RQ5] No fetch or word access while programming
// [RQ6] Programming mode reads return 16-bit units; byte reads are also served and return 8 bits
// [RQ7] Recognised command writes start the embedded algorithm
// [RQ8] Programming proceeds in 16-bit half-words
// [RQ9] Whole-array and single-sector erase both supported
// [RQ10] Reads complete with no inserted wait states
// [RQ11] Array size is 64 KB or 128 KB
// [RQ12] Processor issues one to six half-word command writes
// [RQ13] Unused size encodings leave the mode alone
`timescale 1ns/1ps
`include "famc_map.svh"

module famc_access_ctrl
#(
    parameter int FLASH_KB = `FAMC_KB_LARGE
)
(
    // Clock and reset
    input logic ref_clk_in,
    input logic rstn_in,
    // Access size field
    input logic asz_wr_in,
    input logic [1:0] asz_wdata_in,
    output logic [1:0] access_size_out,
    output logic prog_mode_out,
    // CPU access
    input logic cpu_req_in,
    input logic cpu_we_in,
    input logic cpu_fetch_in,
    input logic [1:0] cpu_size_in,
    input logic [`FAMC_ADDR_W-1:0] cpu_addr_in,
    input logic [15:0] cpu_wdata_in,
    output logic cpu_ack_out,
    output logic cpu_err_out,
    output logic [31:0] cpu_rdata_out,
    // Array read port, data sampled in the same cycle as the read strobe
    output logic arr_rd_out,
    output logic [`FAMC_ADDR_W-1:2] arr_addr_out,
    input logic [31:0] arr_rdata_in,
    // Embedded algorithm launch
    output logic alg_start_out,
    output famc_pkg::famc_op_t alg_op_out,
    output logic [`FAMC_ADDR_W-1:0] alg_addr_out,
    output logic [15:0] alg_data_out
);

    generate
        if (FLASH_KB != `FAMC_KB_SMALL && FLASH_KB != `FAMC_KB_LARGE)
        begin : g_bad_size
            $error("FLASH_KB must be 64 or 128");
        end
    endgenerate

    famc_pkg::famc_ctrl_state_t q;
    famc_pkg::famc_ctrl_state_t d;
    logic in_range;
    logic rom_mode;
    logic bad;
    logic cmd_wr;
    logic seq_start;
    famc_pkg::famc_op_t seq_op;
    logic [`FAMC_ADDR_W-1:0] seq_addr;
    logic [15:0] seq_data;

    // Narrow reads come back right-aligned
    function automatic logic [31:0] lane(input logic [31:0] w,
        input logic [1:0] sz, input logic [1:0] lo);
        logic [31:0] r;
        r = w;
        case (sz)
            `FAMC_SZ_HALF:
                r = {16'h0000, lo[1] ? w[31:16] : w[15:0]};
            `FAMC_SZ_BYTE:
                r = {24'h000000, w[8*lo +: 8]};
            default:
                r = w;
        endcase
        lane = r;
    endfunction

    // Small array mirrors nothing above 64 KB
    assign in_range = (FLASH_KB == `FAMC_KB_LARGE) ||
        !cpu_addr_in[`FAMC_ADDR_W-1]; // [RQ11]
    assign rom_mode = (q.access_size_field == `FAMC_ASZ_WORD);

    always_comb
    begin
        bad = 1'b0;
        cmd_wr = 1'b0;
        if (!in_range)
            bad = 1'b1; // [RQ11]
        else if (rom_mode)
            bad = 1'b0; // [RQ3]
        else if (cpu_fetch_in || cpu_size_in == `FAMC_SZ_WORD)
            bad = 1'b1; // [RQ5]
        else if (cpu_we_in && cpu_size_in != `FAMC_SZ_HALF)
            bad = 1'b1; // [RQ8]
        else if (cpu_we_in)
            cmd_wr = cpu_req_in; // [RQ7]
    end

    // Sequence is flushed as soon as word-read mode is selected
    famc_cmd_seq u_seq
    (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .clear_in(rom_mode), // [RQ3]
        .wr_in(cmd_wr),
        .wr_addr_in(cpu_addr_in),
        .wr_data_in(cpu_wdata_in),
        .start_out(seq_start),
        .op_out(seq_op),
        .addr_out(seq_addr),
        .data_out(seq_data)
    );

    always_comb
    begin
        d = q;
        if (asz_wr_in)
        begin
            if (asz_wdata_in == `FAMC_ASZ_WORD)
            begin
                d.access_size_field = `FAMC_ASZ_WORD; // [RQ2]
                d.prog = 1'b0;
            end
            else if (asz_wdata_in == `FAMC_ASZ_HALF)
            begin
                d.access_size_field = `FAMC_ASZ_HALF; // [RQ4]
                d.prog = 1'b1;
            end
            // Other codes keep the current mode [RQ13]
        end
        // Fixed two-stage read, never stalled [RQ10]
        d.s1_vld = cpu_req_in;
        d.s1_we = cpu_we_in;
        d.s1_err = bad;
        d.s1_size = cpu_size_in;
        d.s1_lane = cpu_addr_in[1:0];
        d.arr_rd = cpu_req_in && !cpu_we_in && !bad;
        d.arr_addr = cpu_addr_in[`FAMC_ADDR_W-1:2];
        d.ack = q.s1_vld; // [RQ10]
        d.err = q.s1_vld && q.s1_err;
        if (q.s1_vld && !q.s1_we && !q.s1_err)
            d.rdata = lane(arr_rdata_in, q.s1_size, q.s1_lane); // [RQ2] [RQ6]
        else
            d.rdata = 32'h00000000;
        // Launch only while programming mode still holds [RQ3]
        d.alg_start = seq_start && !rom_mode; // [RQ7]
        if (seq_start)
        begin
            d.alg_op = seq_op;
            d.alg_addr = seq_addr;
            d.alg_data = seq_data; // [RQ8]
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            q <= '0;
            q.access_size_field <= `FAMC_ASZ_RESET; // [RQ1]
        end
        else
        begin
            q <= d;
        end
    end

    assign access_size_out = q.access_size_field;
    assign prog_mode_out = q.prog;
    assign cpu_ack_out = q.ack;
    assign cpu_err_out = q.err;
    assign cpu_rdata_out = q.rdata;
    assign arr_rd_out = q.arr_rd;
    assign arr_addr_out = q.arr_addr;
    assign alg_start_out = q.alg_start;
    assign alg_op_out = q.alg_op;
    assign alg_addr_out = q.alg_addr;
    assign alg_data_out = q.alg_data;

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_wr(logic [15:0] a, logic [7:0] v);
        cpu_req_in && cpu_we_in && cpu_size_in == `FAMC_SZ_HALF &&
        prog_mode_out && !asz_wr_in && in_range &&
        cpu_addr_in[15:0] == a && cpu_wdata_in[7:0] == v;
    endsequence

    sequence s_any_half_wr;
        cpu_req_in && cpu_we_in && cpu_size_in == `FAMC_SZ_HALF &&
        prog_mode_out && !asz_wr_in && in_range;
    endsequence

    // Writes spaced three cycles apart, as the CPU issues them here
    sequence s_unlock;
        s_wr(`FAMC_CMD_ADDR_A, `FAMC_CMD_UNLOCK_A) ##3
        s_wr(`FAMC_CMD_ADDR_B, `FAMC_CMD_UNLOCK_B);
    endsequence

    // Reset itself is the trigger, so this one is never disabled
    reset_mode_a: assert property (@(posedge ref_clk_in) disable iff (1'b0) // [RQ1]
        !rstn_in |=> access_size_out == `FAMC_ASZ_WORD && !prog_mode_out)
        else $error("mode not word-read after reset");

    word_read_a: assert property ( // [RQ2]
        cpu_req_in && !cpu_we_in && in_range && !prog_mode_out &&
        cpu_size_in == `FAMC_SZ_WORD
        |=> arr_rd_out ##1 cpu_ack_out && !cpu_err_out &&
        cpu_rdata_out == $past(arr_rdata_in))
        else $error("word read not served");

    rom_nocmd_a: assert property ( // [RQ3]
        !$past(prog_mode_out) && !prog_mode_out |-> !alg_start_out)
        else $error("algorithm started in word-read mode");

    prog_enter_a: assert property ( // [RQ4]
        asz_wr_in && asz_wdata_in == `FAMC_ASZ_HALF
        |=> prog_mode_out && access_size_out == `FAMC_ASZ_HALF)
        else $error("programming mode not entered");

    fetch_block_a: assert property ( // [RQ5]
        cpu_req_in && cpu_fetch_in && prog_mode_out
        |-> ##2 cpu_ack_out && cpu_err_out)
        else $error("fetch allowed in programming mode");

    half_read_a: assert property ( // [RQ6]
        cpu_req_in && !cpu_we_in && in_range && prog_mode_out &&
        !cpu_fetch_in && cpu_size_in == `FAMC_SZ_HALF
        |-> ##2 cpu_ack_out && !cpu_err_out && cpu_rdata_out[31:16] == 16'h0000)
        else $error("half-word read malformed");

    prog_cmd_a: assert property ( // [RQ7]
        s_unlock ##3 s_wr(`FAMC_CMD_ADDR_A, `FAMC_CMD_PROG) ##3 s_any_half_wr
        |-> ##2 alg_start_out && alg_op_out == famc_pkg::OP_PROG &&
        alg_data_out == $past(cpu_wdata_in, 2))
        else $error("program command not launched");

    erase_cmd_a: assert property ( // [RQ9]
        s_unlock ##3 s_wr(`FAMC_CMD_ADDR_A, `FAMC_CMD_ERASE) ##3 s_unlock ##3
        s_wr(`FAMC_CMD_ADDR_A, `FAMC_CMD_CHIP)
        |-> ##2 alg_start_out && alg_op_out == famc_pkg::OP_CHIP)
        else $error("chip erase not launched");

    zero_wait_a: assert property ( // [RQ10]
        cpu_req_in |-> ##1 !cpu_ack_out ##1 cpu_ack_out)
        else $error("access answer latency wrong");

    range_err_a: assert property ( // [RQ11]
        cpu_req_in && !in_range |-> ##2 cpu_ack_out && cpu_err_out)
        else $error("out-of-range access accepted");

    keep_mode_a: assert property ( // [RQ13]
        asz_wr_in && asz_wdata_in != `FAMC_ASZ_WORD &&
        asz_wdata_in != `FAMC_ASZ_HALF
        |=> $stable(access_size_out) && $stable(prog_mode_out))
        else $error("unused size code changed mode");

endmodule

// ==== famc_array_model.sv ====
`timescale 1ns/1ps
`include "famc_map.svh"

module famc_array_model
(
    // Array read port
    input logic rd_in,
    input logic [`FAMC_ADDR_W-1:2] addr_in,
    output logic [31:0] rdata_out
);
    logic [31:0] word;
    assign word = {addr_in, 2'h1, ~addr_in};
    // Inverse when idle so a stale sample never matches
    assign rdata_out = rd_in ? word : ~word;
endmodule

// ==== flash_access_mode_control_test.sv ====
`timescale 1ns/1ps
`include "famc_map.svh"

module flash_access_mode_control_test;
    logic ref_clk, rstn, asz_wr, req, we, fetch;
    logic [1:0] asz_wdata, acc_size, size;
    logic prog, ack, err, arr_rd, alg_start;
    logic [16:0] addr, alg_addr;
    logic [16:2] arr_addr;
    logic [15:0] wdata, alg_data;
    logic [31:0] rdata, arr_rdata;
    famc_pkg::famc_op_t alg_op;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    famc_access_ctrl #(.FLASH_KB(64)) famc_access_ctrl_i (
        .ref_clk_in(ref_clk), .rstn_in(rstn),
        .asz_wr_in(asz_wr), .asz_wdata_in(asz_wdata),
        .access_size_out(acc_size), .prog_mode_out(prog),
        .cpu_req_in(req), .cpu_we_in(we), .cpu_fetch_in(fetch),
        .cpu_size_in(size), .cpu_addr_in(addr),
        .cpu_wdata_in(wdata), .cpu_ack_out(ack), .cpu_err_out(err),
        .cpu_rdata_out(rdata), .arr_rd_out(arr_rd),
        .arr_addr_out(arr_addr), .arr_rdata_in(arr_rdata),
        .alg_start_out(alg_start), .alg_op_out(alg_op),
        .alg_addr_out(alg_addr), .alg_data_out(alg_data)
    );
    famc_array_model famc_array_model_i (
        .rd_in(arr_rd), .addr_in(arr_addr), .rdata_out(arr_rdata)
    );

    initial
    begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] aw(logic [16:0] a);
        return {a[16:2], 2'h1, ~a[16:2]};
    endfunction

    task automatic summarize();
        $display("Mismatches %0d of %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk_bit(logic got, logic exp, string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %b", $time, msg, got);
        end
    endtask

    task automatic chk_val(logic [31:0] got, logic [31:0] exp,
                           string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s %h vs %h", $time, msg, got, exp);
        end
    endtask

    // One request; answer looked at two edges after it is taken
    task automatic access(logic w, logic f, logic [1:0] sz,
        logic [16:0] a, logic [15:0] d, output logic e,
        output logic [31:0] r, output logic st);
        @(posedge ref_clk);
        #1;
        req = 1;
        we = w;
        fetch = f;
        size = sz;
        addr = a;
        wdata = d;
        @(posedge ref_clk);
        #1;
        req = 0;
        @(posedge ref_clk);
        #1;
        chk_bit(ack, 1'b1, "ack");
        e = err;
        r = rdata;
        st = alg_start;
    endtask

    task automatic rd(logic f, logic [1:0] sz, logic [16:0] a,
                      logic e_exp, logic [31:0] d_exp);
        logic e, st;
        logic [31:0] r;
        access(1'b0, f, sz, a, 16'h0, e, r, st);
        chk_bit(e, e_exp, "read err");
        chk_val(r, d_exp, "read data");
    endtask

    task automatic set_mode(logic [1:0] v, logic [1:0] exp);
        @(posedge ref_clk);
        #1;
        asz_wr = 1;
        asz_wdata = v;
        @(posedge ref_clk);
        #1;
        asz_wr = 0;
        chk_val({30'h0, acc_size}, {30'h0, exp}, "size field");
        chk_bit(prog, exp == `FAMC_ASZ_HALF, "prog flag");
    endtask

    task automatic send_cmd(int n, logic [16:0] al[6],
                            logic [15:0] dl[6], logic exp);
        logic e, st;
        logic [31:0] r;
        for (int i = 0; i < n; i++)
        begin
            access(1'b1, 1'b0, `FAMC_SZ_HALF, al[i], dl[i], e, r, st);
            chk_bit(e, 1'b0, "write err");
            chk_bit(st, (i == n - 1) ? exp : 1'b0, "launch");
        end
    endtask

    task automatic chk_alg(famc_pkg::famc_op_t op, logic [16:0] a,
                           logic [15:0] d);
        chk_val({30'h0, alg_op}, {30'h0, op}, "alg op");
        chk_val({15'h0, alg_addr}, {15'h0, a}, "alg addr");
        chk_val({16'h0, alg_data}, {16'h0, d}, "alg data");
    endtask

    task automatic t_rom();
        logic [16:0] p[6] = '{17'haa8, 17'h554, 17'haa8, 17'h0c3a6, 0, 0};
        logic [15:0] q[6] = '{16'haa, 16'h55, 16'ha0, 16'h1234, 0, 0};
        chk_val({30'h0, acc_size}, 32'h2, "reset size");
        rd(1'b0, `FAMC_SZ_WORD, 17'h0a0c7, 1'b0, aw(17'h0a0c7));
        rd(1'b1, `FAMC_SZ_WORD, 17'h0fffc, 1'b0, aw(17'h0fffc));
        rd(1'b0, `FAMC_SZ_WORD, 17'h10000, 1'b1, 32'h0);
        send_cmd(4, p, q, 1'b0);
        set_mode(2'h0, 2'h2);
        set_mode(2'h3, 2'h2);
    endtask

    task automatic t_prog();
        logic [31:0] w = aw(17'h0b5e4);
        set_mode(2'h1, 2'h1);
        set_mode(2'h3, 2'h1);
        rd(1'b1, `FAMC_SZ_HALF, 17'h0b5e4, 1'b1, 32'h0);
        rd(1'b0, `FAMC_SZ_WORD, 17'h0b5e4, 1'b1, 32'h0);
        rd(1'b0, `FAMC_SZ_HALF, 17'h0b5e4, 1'b0, {16'h0, w[15:0]});
        rd(1'b0, `FAMC_SZ_HALF, 17'h0b5e6, 1'b0, {16'h0, w[31:16]});
        rd(1'b0, `FAMC_SZ_BYTE, 17'h0b5e7, 1'b0, {24'h0, w[31:24]});
    endtask

    task automatic t_cmds();
        logic [16:0] p[6] = '{17'haa8, 17'h554, 17'haa8, 17'h0c3a6, 0, 0};
        logic [15:0] q[6] = '{16'h77aa, 16'h55, 16'ha0, 16'h12f0, 0, 0};
        logic [16:0] c[6] = '{17'haa8, 17'h554, 17'haa8, 17'haa8,
                              17'h554, 17'haa8};
        logic [15:0] x[6] = '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55,
                              16'h10};
        send_cmd(4, p, q, 1'b1);
        chk_alg(famc_pkg::OP_PROG, 17'h0c3a6, 16'h12f0);
        send_cmd(6, c, x, 1'b1);
        chk_alg(famc_pkg::OP_CHIP, 17'haa8, 16'h0010);
        c[5] = 17'h0e002;
        x[5] = 16'h30;
        send_cmd(6, c, x, 1'b1);
        chk_alg(famc_pkg::OP_SECT, 17'h0e002, 16'h0030);
    endtask

    task automatic t_reset_prog();
        @(posedge ref_clk);
        #1;
        rstn = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        rstn = 1;
        chk_val({30'h0, acc_size}, 32'h2, "size after reset");
        chk_bit(prog, 1'b0, "prog after reset");
        rd(1'b1, `FAMC_SZ_WORD, 17'h00010, 1'b0, aw(17'h00010));
    endtask

    initial
    begin
        rstn = 0;
        asz_wr = 0;
        asz_wdata = 2'h0;
        req = 0;
        we = 0;
        fetch = 0;
        size = 2'h0;
        addr = 17'h0;
        wdata = 16'h0;
        repeat (6) @(posedge ref_clk);
        #1;
        rstn = 1;
        t_rom();
        t_prog();
        t_cmds();
        t_reset_prog();
        summarize();
    end
endmodule
